/* adc_reference_trigger_sequencer.sv */
// Reference, trigger and sample sequencer of the converter timing engine.
//
// Overview of operation
// - Decode reference bits: off, manual, auto, invalid.
// - Auto mode with long wait raises reference 8 ms before a launch's first conversion.
// - Auto with short wait keeps reference on.
// - Auto long wait: reference on 8 ms early after launch and for the last 8 ms of each gap.
// - Writing engine reset returns engine to idle.
// - Engine reset bit self-clears as the first conversion is entered from a delay or settle, or from idle only while first_ff is still set from an earlier launch.
// - Interval code doubles from 0.062 ms upward.
// - Select bits choose pin four, pin two.
// - Both pins ORed before edge detection.
// - Holdoff makes trigger a level gate.
// - Without holdoff, cycle runs to completion.
// - Holdoff pauses; resume after trigger delay.
// - Delay code sets trigger-to-conversion wait.
// - Armed engine waits for trigger without timeout.
// - Sum 16 bits, min and max 10 bits.
// - Result count is input over full scale.
// - Writing enable launches or arms the cycle.
// - Each pin individually inverting or non-inverting.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"

module adc_reference_trigger_sequencer #(
  parameter int unsigned REF_SETTLE_CYCLES = `REF_SETTLE_CYC,
  parameter int unsigned WAIT_BASE_CYCLES = `WAIT_BASE_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic gp_pin_two,
  input wire logic gp_pin_four,
  input wire logic pin_two_invert,
  input wire logic pin_four_invert,
  output logic conv_req,
  input wire logic conv_done,
  input wire adc_seq_pkg::sample_t conv_data,
  output logic [3:0] channel_select,
  output logic ref_enable,
  output logic converter_enable,
  output logic conversion_busy_flag,
  output logic cycle_done,
  output logic ref_mode_invalid
);
  import adc_seq_pkg::*;

  function automatic tmr_t wait_len(input logic [3:0] code);
    if (code == 4'h0) begin
      wait_len = '0;
    end else begin
      wait_len = tmr_t'(WAIT_BASE_CYCLES) << (code - 4'h1);
    end
  endfunction

  function automatic tmr_t delay_len(input logic [2:0] code);
    case (code)
      3'h1: delay_len = tmr_t'(`US_CYC(`TDLY1_US));
      3'h2: delay_len = tmr_t'(`US_CYC(`TDLY2_US));
      3'h3: delay_len = tmr_t'(`US_CYC(`TDLY3_US));
      3'h4: delay_len = tmr_t'(`US_CYC(`TDLY4_US));
      3'h5: delay_len = tmr_t'(`US_CYC(`TDLY5_US));
      3'h6: delay_len = tmr_t'(`US_CYC(`TDLY6_US));
      3'h7: delay_len = tmr_t'(`US_CYC(`TDLY7_US));
      default: delay_len = '0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and trigger qualification.

  logic p2_meta_ff, p2_ff, p4_meta_ff, p4_ff, act_prev_ff;
  logic nxt_p2_meta, nxt_p2, nxt_p4_meta, nxt_p4, nxt_act_prev;
  logic trig_active, trig_edge;

  always_comb begin
    nxt_p2_meta = gp_pin_two;
    nxt_p2 = p2_meta_ff;
    nxt_p4_meta = gp_pin_four;
    nxt_p4 = p4_meta_ff;
    nxt_act_prev = trig_active;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      p2_meta_ff <= 1'b0;
      p2_ff <= 1'b0;
      p4_meta_ff <= 1'b0;
      p4_ff <= 1'b0;
      act_prev_ff <= 1'b0;
    end else if (clk_en) begin
      p2_meta_ff <= nxt_p2_meta;
      p2_ff <= nxt_p2;
      p4_meta_ff <= nxt_p4_meta;
      p4_ff <= nxt_p4;
      act_prev_ff <= nxt_act_prev;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Registers and the sequencing engine.

  logic [7:0] set_ff, timing_ff, trig_ff, rdata_ff;
  logic [7:0] nxt_set, nxt_timing, nxt_trig, nxt_rdata;
  seq_state_t state_ff, nxt_state;
  tmr_t tmr_ff, nxt_tmr;
  logic [6:0] cnt_ff, nxt_cnt;
  logic [15:0] acc_ff, nxt_acc, sum_ff, nxt_sum;
  sample_t amax_ff, nxt_amax, amin_ff, nxt_amin;
  sample_t max_ff, nxt_max, min_ff, nxt_min;
  logic first_ff, nxt_first, ref_ff, nxt_ref, done_ff, nxt_done;
  logic auto_ref, man_ref, mode_ok, ext_sel, hold_pause, go_ref;
  logic launch, eng_reset, last;
  logic [6:0] total;
  logic [15:0] acc_new;
  sample_t max_new, min_new;

  // Polarity and select are applied after the second stage, and the OR
  // comes before the edge detector so either pin can start the cycle.
  assign trig_active = (trig_ff[`TR_SEL2] & (p2_ff ^ pin_two_invert)) |
                       (trig_ff[`TR_SEL4] & (p4_ff ^ pin_four_invert));
  assign trig_edge = trig_active & ~act_prev_ff;

  assign auto_ref = timing_ff[`TM_AUTO];
  assign man_ref = timing_ff[`TM_REFEN];
  assign mode_ok = auto_ref ^ man_ref;
  assign ext_sel = trig_ff[`TR_SEL4] | trig_ff[`TR_SEL2];
  // Suspension only applies to pin triggering and only when every selected pin is idle.
  assign hold_pause = trig_ff[`TR_HOLD] & ext_sel & ~trig_active;
  assign go_ref = auto_ref &
    (wait_len(timing_ff[3:0]) >= tmr_t'(REF_SETTLE_CYCLES));
  assign launch = reg_wr && reg_addr == `ADDR_CONV_SET &&
                  reg_wdata[`CS_EN];
  assign eng_reset = reg_wr && reg_addr == `ADDR_TIMING &&
                     reg_wdata[`TM_RESET];

  always_comb begin
    case (set_ff[5:4])
      2'b01: total = 7'd16;
      2'b10: total = 7'd32;
      2'b11: total = 7'd64;
      default: total = 7'd1;
    endcase
  end

  // The sample value is the converter count, already scaled to 1023.
  assign acc_new = acc_ff + 16'(conv_data);
  assign max_new = (conv_data > amax_ff) ? conv_data : amax_ff;
  assign min_new = (conv_data < amin_ff) ? conv_data : amin_ff;
  assign last = (cnt_ff + 7'd1) == total;

  always_comb begin
    nxt_set = set_ff;
    nxt_timing = timing_ff;
    nxt_trig = trig_ff;
    nxt_rdata = rdata_ff;
    nxt_state = state_ff;
    nxt_tmr = tmr_ff;
    nxt_cnt = cnt_ff;
    nxt_acc = acc_ff;
    nxt_amax = amax_ff;
    nxt_amin = amin_ff;
    nxt_sum = sum_ff;
    nxt_max = max_ff;
    nxt_min = min_ff;
    nxt_first = first_ff;
    nxt_done = 1'b0;

    case (state_ff)
      ST_IDLE: begin
        if (launch && mode_ok) begin
          nxt_acc = '0;
          nxt_amax = '0;
          nxt_amin = `MIN_INIT;
          nxt_cnt = '0;
          nxt_first = 1'b1;
          if (ext_sel) begin
            nxt_state = ST_ARMED;
          end else if (go_ref) begin
            nxt_state = ST_REFUP;
            nxt_tmr = tmr_t'(REF_SETTLE_CYCLES - 1);
          end else begin
            nxt_state = ST_CONVERT;
          end
        end
      end
      ST_ARMED: begin
        // No timeout: the engine waits here for as long as it takes.
        if (trig_edge) begin
          nxt_state = ST_TDELAY;
          nxt_tmr = delay_len(trig_ff[2:0]);
        end
      end
      ST_TDELAY, ST_REFUP, ST_GAP: begin
        if (hold_pause) begin
          nxt_state = ST_SUSPEND;
        end else if (tmr_ff != '0) begin
          nxt_tmr = tmr_ff - tmr_t'(1);
        end else if (state_ff == ST_TDELAY && go_ref && first_ff) begin
          nxt_state = ST_REFUP;
          nxt_tmr = tmr_t'(REF_SETTLE_CYCLES - 1);
        end else begin
          nxt_state = ST_CONVERT;
        end
      end
      ST_SUSPEND: begin
        if (!hold_pause) begin
          nxt_state = ST_TDELAY;
          nxt_tmr = delay_len(trig_ff[2:0]);
        end
      end
      ST_CONVERT: begin
        if (conv_done) begin
          nxt_acc = acc_new;
          nxt_amax = max_new;
          nxt_amin = min_new;
          nxt_cnt = cnt_ff + 7'd1;
          if (last) begin
            nxt_sum = acc_new;
            nxt_max = max_new;
            nxt_min = min_new;
            nxt_done = 1'b1;
            nxt_acc = '0;
            nxt_amax = '0;
            nxt_amin = `MIN_INIT;
            nxt_cnt = '0;
            if (set_ff[`CS_REPEAT] && set_ff[`CS_EN]) begin
              nxt_state = ext_sel ? ST_ARMED : ST_CONVERT;
            end else begin
              nxt_state = ST_IDLE;
            end
          end else if (wait_len(timing_ff[3:0]) != '0) begin
            nxt_state = ST_GAP;
            nxt_tmr = wait_len(timing_ff[3:0]) - tmr_t'(1);
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase

    if (nxt_state == ST_CONVERT && state_ff != ST_CONVERT && first_ff) begin
      nxt_first = 1'b0;
      nxt_timing[`TM_RESET] = 1'b0;
    end

    if (eng_reset) begin
      nxt_state = ST_IDLE;
    end

    // Host writes come last so a write of 1 beats the self-clear.
    if (reg_wr) begin
      case (reg_addr)
        `ADDR_CONV_SET: nxt_set = reg_wdata;
        `ADDR_TIMING: nxt_timing = reg_wdata & `TIMING_WMASK;
        `ADDR_TRIG_DELAY: nxt_trig = reg_wdata & `TRIG_WMASK;
        default: nxt_set = set_ff;
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        `ADDR_CONV_SET: nxt_rdata = set_ff;
        `ADDR_TIMING: nxt_rdata = timing_ff;
        `ADDR_TRIG_DELAY: nxt_rdata = trig_ff;
        `ADDR_SUM_HI: nxt_rdata = sum_ff[15:8];
        `ADDR_SUM_LO: nxt_rdata = sum_ff[7:0];
        `ADDR_MAX_HI: nxt_rdata = {6'h00, max_ff[9:8]};
        `ADDR_MAX_LO: nxt_rdata = max_ff[7:0];
        `ADDR_MIN_HI: nxt_rdata = {6'h00, min_ff[9:8]};
        `ADDR_MIN_LO: nxt_rdata = min_ff[7:0];
        default: nxt_rdata = 8'h00;
      endcase
    end

    // In auto mode with a long interval the reference is dropped between
    // samples to save power and raised again one settle time early.
    if (!mode_ok) begin
      nxt_ref = 1'b0;
    end else if (man_ref) begin
      nxt_ref = 1'b1;
    end else if (!go_ref) begin
      nxt_ref = 1'b1;
    end else begin
      case (nxt_state)
        ST_TDELAY, ST_REFUP, ST_CONVERT, ST_SUSPEND: nxt_ref = 1'b1;
        ST_GAP: nxt_ref = nxt_tmr < tmr_t'(REF_SETTLE_CYCLES);
        default: nxt_ref = 1'b0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      set_ff <= `RST_CONV_SET;
      timing_ff <= `RST_TIMING;
      trig_ff <= `RST_TRIG_DELAY;
      rdata_ff <= 8'h00;
      state_ff <= ST_IDLE;
      tmr_ff <= '0;
      cnt_ff <= '0;
      acc_ff <= '0;
      amax_ff <= '0;
      amin_ff <= `MIN_INIT;
      sum_ff <= '0;
      max_ff <= '0;
      min_ff <= '0;
      first_ff <= 1'b0;
      ref_ff <= 1'b0;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      set_ff <= nxt_set;
      timing_ff <= nxt_timing;
      trig_ff <= nxt_trig;
      rdata_ff <= nxt_rdata;
      state_ff <= nxt_state;
      tmr_ff <= nxt_tmr;
      cnt_ff <= nxt_cnt;
      acc_ff <= nxt_acc;
      amax_ff <= nxt_amax;
      amin_ff <= nxt_amin;
      sum_ff <= nxt_sum;
      max_ff <= nxt_max;
      min_ff <= nxt_min;
      first_ff <= nxt_first;
      ref_ff <= nxt_ref;
      done_ff <= nxt_done;
    end
  end

  assign reg_rdata = rdata_ff;
  assign conv_req = (state_ff == ST_CONVERT);
  assign channel_select = set_ff[3:0];
  assign ref_enable = ref_ff;
  assign converter_enable = mode_ok;
  assign conversion_busy_flag = (state_ff != ST_IDLE);
  assign cycle_done = done_ff;
  assign ref_mode_invalid = auto_ref & man_ref;

endmodule // adc_reference_trigger_sequencer

/* adc_seq_defs.svh */
// Offsets, field positions, reset values and timing counts of the sequencer.
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

`define ADDR_CONV_SET 8'h61
`define ADDR_TIMING 8'h62
`define ADDR_TRIG_DELAY 8'h67
`define ADDR_SUM_HI 8'h94
`define ADDR_SUM_LO 8'h95
`define ADDR_MAX_HI 8'h96
`define ADDR_MAX_LO 8'h97
`define ADDR_MIN_HI 8'h98
`define ADDR_MIN_LO 8'h99

`define CS_EN 7
`define CS_REPEAT 6
`define TM_RESET 7
`define TM_AUTO 5
`define TM_REFEN 4
`define TR_SEL4 7
`define TR_SEL2 6
`define TR_HOLD 5

`define RST_CONV_SET 8'h00
`define RST_TIMING 8'h00
`define RST_TRIG_DELAY 8'h00
`define TIMING_WMASK 8'hBF
`define TRIG_WMASK 8'hE7

`define CLK_HZ 20000000
`define REF_SETTLE_MS 8
`define REF_SETTLE_CYC (`REF_SETTLE_MS * `CLK_HZ / 1000)
`define WAIT_BASE_US 62
`define WAIT_BASE_CYC (`WAIT_BASE_US * `CLK_HZ / 1000000)
`define TDLY1_US 50
`define TDLY2_US 100
`define TDLY3_US 150
`define TDLY4_US 200
`define TDLY5_US 250
`define TDLY6_US 350
`define TDLY7_US 450
`define US_CYC(us) ((us) * (`CLK_HZ / 1000000))

`define MIN_INIT 10'h3FF
`endif

/* adc_seq_pkg.sv */
// Types shared by the reference and trigger sequencer.
package adc_seq_pkg;
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ARMED   = 3'b001,
    ST_TDELAY  = 3'b010,
    ST_REFUP   = 3'b011,
    ST_CONVERT = 3'b100,
    ST_GAP     = 3'b101,
    ST_SUSPEND = 3'b110
  } seq_state_t;
  typedef logic [24:0] tmr_t;
  typedef logic [9:0] sample_t;
endpackage

/* adc_seq_assertions.sv */
// Port-level assertions for the reference and trigger sequencer.
`timescale 1ns/1ps
module adc_seq_checker (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic conv_req,
  input wire logic conv_done,
  input wire logic converter_enable,
  input wire logic conversion_busy_flag,
  input wire logic cycle_done,
  input wire logic ref_mode_invalid
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic wr_go;
  logic wr_rst;
  logic busy;
  assign busy = conversion_busy_flag;
  assign wr_go = clk_en && reg_wr && reg_addr == 8'h61 && reg_wdata[7];
  assign wr_rst = clk_en && reg_wr && reg_addr == 8'h62 && reg_wdata[7];
  ////////////////////////////////////////////////////////////////////////////
  launch_starts_a: assert property (
    wr_go && !busy && converter_enable |=> busy)
    else $error("launch write left the engine idle");
  invalid_no_launch_a: assert property (
    wr_go && !busy && ref_mode_invalid |=> !busy)
    else $error("launch accepted in invalid mode");
  invalid_disables_a: assert property (
    ref_mode_invalid |-> !converter_enable)
    else $error("converter enabled in invalid mode");
  reset_idles_a: assert property (
    wr_rst |=> !busy)
    else $error("engine reset did not return to idle");
  busy_ends_a: assert property (
    $fell(busy) |-> $past(conv_done) || $past(wr_rst))
    else $error("cycle ended without sample or reset");
  req_in_busy_a: assert property (
    conv_req |-> busy)
    else $error("sample request while idle");
  done_pulse_a: assert property (
    cycle_done |=> !cycle_done)
    else $error("cycle end pulse too long");
  done_cause_a: assert property (
    cycle_done |-> $past(conv_done) && !busy)
    else $error("results stored without final sample");
endmodule // adc_seq_checker

bind adc_reference_trigger_sequencer adc_seq_checker chk_u (.clk(clk),
  .reset_n(reset_n), .clk_en(clk_en), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .conv_req(conv_req),
  .conv_done(conv_done), .converter_enable(converter_enable),
  .conversion_busy_flag(conversion_busy_flag), .cycle_done(cycle_done),
  .ref_mode_invalid(ref_mode_invalid));

/* adc_conv_model.sv */
// Converter model answering sample requests with a ramp of counts.
`timescale 1ns/1ps
module adc_conv_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic conv_req,
  input wire logic busy,
  input wire logic slow,
  input wire logic [9:0] base,
  output logic conv_done,
  output logic [9:0] conv_data
);
  logic [2:0] cnt_ff;
  logic [5:0] k_ff;
  logic [9:0] last_ff;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 3'h0;
      k_ff <= 6'h00;
      last_ff <= 10'h000;
      conv_done <= 1'b0;
    end else begin
      conv_done <= 1'b0;
      if (!busy) begin
        k_ff <= 6'h00;
      end
      if (conv_req && !conv_done) begin
        cnt_ff <= cnt_ff + 3'h1;
        if (cnt_ff == (slow ? 3'h5 : 3'h0)) begin
          cnt_ff <= 3'h0;
          k_ff <= k_ff + 6'h01;
          conv_done <= 1'b1;
          last_ff <= base + 10'(k_ff) * 10'h005;
        end
      end
    end
  end
  // Outside the strobe the data is inverted so a stale read shows up.
  assign conv_data = conv_done ? last_ff : ~last_ff;
endmodule // adc_conv_model

/* tb_top.sv */
// Self-checking testbench of the sequencer.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module tb_top;
  import adc_seq_pkg::*;
  logic clk = 1'b0;
  logic reset_n, reg_wr, reg_rd, pin2, pin4, inv2, inv4, slow;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic conv_req, conv_done, ref_enable, conv_en, busy, done, invalid;
  sample_t conv_data;
  logic [9:0] base;
  logic [3:0] chan;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;
  always #25 clk = ~clk;
  adc_reference_trigger_sequencer #(.REF_SETTLE_CYCLES(20),
    .WAIT_BASE_CYCLES(4)) dut_u (.clk(clk), .reset_n(reset_n),
    .clk_en(1'b1), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gp_pin_two(pin2),
    .gp_pin_four(pin4), .pin_two_invert(inv2), .pin_four_invert(inv4),
    .conv_req(conv_req), .conv_done(conv_done), .conv_data(conv_data),
    .channel_select(chan), .ref_enable(ref_enable),
    .converter_enable(conv_en),
    .conversion_busy_flag(busy), .cycle_done(done),
    .ref_mode_invalid(invalid));
  adc_conv_model conv_u (.clk(clk), .reset_n(reset_n), .conv_req(conv_req),
    .busy(busy), .slow(slow), .base(base), .conv_done(conv_done),
    .conv_data(conv_data));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chkb(input string nm, input logic e, input logic g);
    chk(nm, {15'h0000, e}, {15'h0000, g});
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a,
    input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
    chk(nm, {8'h00, e}, {8'h00, d});
  endtask
  // Bounded so a stuck engine ends the wait and the test carries on instead of hanging the run.
  task automatic wait_req;
    n = 0;
    #1;
    while (conv_req !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task automatic finish_cycle(input int cnt);
    int s;
    logic [9:0] mx;
    s = 0;
    for (int i = 0; i < cnt; i++) s += base + 5 * i;
    mx = base + 10'(5 * (cnt - 1));
    n = 0;
    while (done !== 1'b1 && n < 3000) begin
      @(posedge clk);
      #1 n++;
    end
    chkb("cycle end", 1'b1, n < 3000);
    chkb("idle after", 1'b0, busy);
    rchk("sum hi", 8'h94, s[15:8]);
    rchk("sum lo", 8'h95, s[7:0]);
    rchk("max hi", 8'h96, {6'h00, mx[9:8]});
    rchk("max lo", 8'h97, mx[7:0]);
    rchk("min hi", 8'h98, {6'h00, base[9:8]});
    rchk("min lo", 8'h99, base[7:0]);
    wr(8'h61, 8'h00);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #(50 * 20000);
    n_mismatch++;
    conclude;
  end
  initial begin
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    {pin2, pin4, inv2, inv4, slow} = 5'b01010;
    base = 10'h155;
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    rchk("set reg", 8'h61, 8'h00);
    rchk("timing reg", 8'h62, 8'h00);
    wr(8'h63, 8'h5A);
    rchk("unmapped", 8'h63, 8'h00);
    wr(8'h67, 8'hFF);
    rchk("delay mask", 8'h67, 8'hE7);
    wr(8'h67, 8'h00);
    wr(8'h62, 8'h30);
    #1 chk("invalid", 16'h0002, {14'h0000, invalid, conv_en});
    wr(8'h61, 8'h80);
    #1 chkb("no launch", 1'b0, busy);
    $display("test registers done");
    wr(8'h61, 8'h00);
    wr(8'h62, 8'h11);
    repeat (20) @(posedge clk);
    #1 chkb("manual ref", 1'b1, ref_enable);
    wr(8'h61, 8'h80);
    finish_cycle(1);
    $display("test manual single done");
    {base, slow} <= {10'h100, 1'b1};
    wr(8'h62, 8'h21);
    repeat (2) @(posedge clk);
    #1 chkb("short ref", 1'b1, ref_enable);
    wr(8'h61, 8'h95);
    #1 chk("channel", 16'h0005, {12'h000, chan});
    finish_cycle(16);
    $display("test auto multi done");
    slow <= 1'b0;
    wr(8'h62, 8'h24);
    repeat (2) @(posedge clk);
    #1 chkb("long ref idle", 1'b0, ref_enable);
    wr(8'h61, 8'h80);
    wait_req;
    chkb("ref lead", 1'b1, n >= 20 && n <= 22);
    chkb("ref on", 1'b1, ref_enable);
    finish_cycle(1);
    $display("test auto long done");
    chkb("busy clear", 1'b0, busy);
    wr(8'h62, 8'h20);
    wr(8'h67, 8'h41);
    wr(8'h61, 8'h80);
    repeat (300) @(posedge clk);
    #1 chk("armed", 16'h0002, {14'h0000, busy, conv_req});
    @(posedge clk);
    pin2 <= 1'b1;
    wait_req;
    n = n - `US_CYC(`TDLY1_US);
    chkb("trig delay", 1'b1, n >= 1 && n <= 6);
    finish_cycle(1);
    // Pin two must be inactive, or the ORed trigger never shows an edge.
    pin2 <= 1'b0;
    wr(8'h67, 8'hC0);
    wr(8'h61, 8'h80);
    @(posedge clk);
    pin4 <= 1'b0;
    wait_req;
    chkb("inverted edge", 1'b1, n >= 1 && n <= 6);
    finish_cycle(1);
    wr(8'h67, 8'h61);
    wr(8'h61, 8'h80);
    @(posedge clk);
    pin2 <= 1'b1;
    repeat (100) @(posedge clk);
    pin2 <= 1'b0;
    repeat (1200) @(posedge clk);
    #1 chk("held", 16'h0002, {14'h0000, busy, conv_req});
    @(posedge clk);
    pin2 <= 1'b1;
    wait_req;
    n = n - `US_CYC(`TDLY1_US);
    chkb("resume delay", 1'b1, n >= 1 && n <= 6);
    finish_cycle(1);
    pin2 <= 1'b0;
    $display("test triggers done");
    wr(8'h67, 8'h40);
    wr(8'h61, 8'h80);
    #1 chkb("armed again", 1'b1, busy);
    wr(8'h62, 8'hA0);
    #1 chkb("engine reset", 1'b0, busy);
    rchk("reset held", 8'h62, 8'hA0);
    wr(8'h67, 8'h00);
    wr(8'h61, 8'h00);
    wr(8'h61, 8'h80);
    finish_cycle(1);
    rchk("reset cleared", 8'h62, 8'h20);
    $display("test engine reset done");
    conclude;
  end
endmodule // tb_top
